// file: include/vdcu_pkg.sv
// Function
// - byte a4 reads buffer at pointer, a2 writes at pointer, both delayed.
// - byte ac reads, aa writes at cursor; cursor address unchanged.
// - byte ad reads, ab writes at cursor, then cursor increments.
// - byte a9 increments the cursor address by one.
// - bb block-writes cursor to pointer; bd block-reads the same range.
// - instantaneous commands act after strobe end, anytime; reset sets the delayed-ready flag, reset/reset-status clear the ready status bit.
// - reset drives syncs low, blank high; blank stays until display on.
// - reset clears interrupt, status and mask bits; delayed-ready flag set.
// - reset: row buffer, cursor off, display off, graphics off, pointer zero.
// - load-pointer copies low four data bits; host uses 0 to 14.
// - graphics advances address every scan line; change takes effect at row boundary.
// - graphics active strobes lowest address line at blank trailing edge.
// - display off raises blank; bit 2 floats the address outputs.
// - display on restores blank next field (bit2=1) or line; drivers on.
// - cursor off holds cursor low; cursor on restores matching.
// - reset-status clears selected bits: split2, ready, split1, line0, vblank.
// - disable/enable interrupt clears/sets selected mask bits, same mapping.
// - delayed commands other than a9 wait for horizontal blank in active time, else run at once.
// - increment cursor starts at once, completes in about three clocks.
// - block write runs in blanking intervals, pauses in active display, resumes.
// - delayed-ready reads zero while a delayed command runs, else one.
// - ready status bit sets when a delayed command finishes.
package vdcu_pkg;
    localparam logic [7:0] CMD_RD_PTR     = 8'ha4;
    localparam logic [7:0] CMD_WR_PTR     = 8'ha2;
    localparam logic [7:0] CMD_INC_CUR    = 8'ha9;
    localparam logic [7:0] CMD_RD_CUR     = 8'hac;
    localparam logic [7:0] CMD_WR_CUR     = 8'haa;
    localparam logic [7:0] CMD_RD_CUR_INC = 8'had;
    localparam logic [7:0] CMD_WR_CUR_INC = 8'hab;
    localparam logic [7:0] CMD_BLK_WR     = 8'hbb;
    localparam logic [7:0] CMD_BLK_RD     = 8'hbd;
    localparam logic [7:0] CMD_MRESET     = 8'h00;
    // opcode groups in the upper bits
    localparam logic [3:0] GRP_LOAD_PTR   = 4'h1;
    localparam logic [2:0] GRP_MODE       = 3'h1;
    localparam logic [2:0] GRP_CLR_STAT   = 3'h2;
    localparam logic [2:0] GRP_DIS_INT    = 3'h4;
    localparam logic [2:0] GRP_EN_INT     = 3'h3;
    // status bit positions
    localparam int ST_SPLIT2 = 0;
    localparam int ST_READY  = 1;
    localparam int ST_SPLIT1 = 2;
    localparam int ST_LINE0  = 3;
    localparam int ST_VBLANK = 4;
    localparam int NSTAT     = 5;
    // mode command field positions
    localparam int MB_ONOFF  = 0;
    localparam int MB_KIND   = 1;
    localparam int MB_OPT    = 2;
    localparam int MB_DISP   = 3;
    localparam int MB_CURS   = 4;
    localparam logic [3:0] PTR_RESET = 4'h0;
    // increment cursor duration
    localparam int CLK_MHZ      = 100;
    localparam int INC_TIME_NS  = 30;
    localparam int INC_CYCLES   = (INC_TIME_NS * CLK_MHZ) / 1000;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_ACC   = 3'b010,
        ST_INC   = 3'b011,
        ST_BLOCK = 3'b100
    } dly_state_t;
endpackage

// file: sim/host_cmd_model.sv
`timescale 1ns/1ps
// host side: one byte per strobe
module host_cmd_model (
    input  wire logic       core_clk,
    input  wire logic       rdy,
    output logic            cmd_wr_n,
    output logic [7:0]      cmd_data
);
    initial begin
        cmd_wr_n = 1'b1;
        cmd_data = 8'h55;
    end
    // byte held past strobe rise
    task automatic send(input logic [7:0] b);
        int n = 0;
        while (b[7:5] == 3'h5 && rdy !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        cmd_data = b;
        cmd_wr_n = 1'b0;
        repeat (3) @(negedge core_clk);
        cmd_wr_n = 1'b1;
        repeat (3) @(negedge core_clk);
        cmd_data = ~b; // no stale byte
        repeat (2) @(negedge core_clk);
    endtask
endmodule

// file: sim/vdcu_asserts.sv
`timescale 1ns/1ps
// pin-level checks of the command unit
module vdcu_asserts #(
    parameter int ADDR_W = 14
) (
    input wire logic              core_clk,
    input wire logic              nrst,
    input wire logic              hblank_in,
    input wire logic              cursor_match,
    input wire logic              reset_busy,
    input wire logic              mem_req,
    input wire logic              mem_ack,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              graphics_active,
    input wire logic              line_graphics_strobe,
    input wire logic              display_address_bus_oe,
    input wire logic              blank_out,
    input wire logic              hsync_en,
    input wire logic              vsync_en,
    input wire logic              cursor_out,
    input wire logic [4:0]        irq_bits,
    input wire logic [5:0]        status_bits,
    input wire logic [4:0]        irq_mask,
    input wire logic              interrupt_output,
    input wire logic              delayed_ready_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    property p_reset_blank;
        reset_busy |-> blank_out && !hsync_en && !vsync_en;
    endproperty
    a_reset_blank: assert property (p_reset_blank) else $error("sync or blank");
    property p_cursor_low;
        !cursor_match |-> !cursor_out;
    endproperty
    a_cursor_low: assert property (p_cursor_low) else $error("cursor out");
    // latch only where mask set
    property p_irq;
        interrupt_output == (|irq_bits) && (irq_bits & ~$past(irq_bits) & ~$past(irq_mask)) == 0;
    endproperty
    a_irq: assert property (p_irq) else $error("irq latch");
    property p_ready_mirror;
        status_bits[5] == delayed_ready_flag;
    endproperty
    a_ready_mirror: assert property (p_ready_mirror) else $error("ready mirror");
    property p_req_hold;
        mem_req && !mem_ack ##1 blank_out |-> mem_req && $stable(mem_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_req_blank;
        mem_req |-> blank_out && !delayed_ready_flag;
    endproperty
    a_req_blank: assert property (p_req_blank) else $error("access in active");
    property p_lg;
        line_graphics_strobe |-> graphics_active && $fell(hblank_in);
    endproperty
    a_lg: assert property (p_lg) else $error("graphics strobe");
    property p_float;
        !display_address_bus_oe |-> blank_out;
    endproperty
    a_float: assert property (p_float) else $error("float unblanked");
    c_acc: cover property (mem_req && mem_ack);
    c_lg: cover property (line_graphics_strobe);
    c_rdy: cover property ($rose(delayed_ready_flag));
endmodule

bind video_display_command_unit vdcu_asserts #(.ADDR_W(ADDR_W)) i_chk (.*);

// file: sim/video_display_command_unit_test.sv
`timescale 1ns/1ps
module video_display_command_unit_test;
    logic        core_clk, nrst, cmd_wr_n, hblank_in, vretrace_in, field_start, line_start;
    logic        row_boundary, cursor_match, reset_busy, mem_req, mem_we, mem_ack, cur_load;
    logic        init_two_top_bit_clr, graphics_active, mac_per_line, line_graphics_strobe;
    logic        display_address_bus_oe, blank_out, hsync_en, vsync_en, cursor_out;
    logic        row_buffer_mode, interrupt_output, delayed_ready_flag;
    logic [7:0]  cmd_data;
    logic [4:0]  stat_events, irq_bits, irq_mask;
    logic [5:0]  status_bits;
    logic [3:0]  init_reg_pointer;
    logic [13:0] mac_addr, cur_load_val, ptr_addr, mem_addr, cursor_addr;
    int          n_mismatch, comparisons, cyc;
    video_display_command_unit #(.ADDR_W(14)) i_dut (.*);
    host_cmd_model i_host (.core_clk, .rdy(delayed_ready_flag), .cmd_wr_n, .cmd_data);
    ////////////////////////////////////////
    always #5 core_clk = ~core_clk;
    // hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] b);
        i_host.send(b);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic ev(input logic [4:0] v);
        stat_events = v;
        @(negedge core_clk);
        stat_events = 5'h0;
        @(negedge core_clk);
    endtask
    // one buffer word; ack dropped a cycle between words
    task automatic mem(input logic [13:0] a, input logic we);
        int n = 0;
        while (mem_req !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        chk({mem_req, mem_we, mem_addr}, {1'b1, we, a});
        mem_ack = 1'b1;
        @(negedge core_clk);
        mem_ack = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic wait_rdy();
        int n = 0;
        while (delayed_ready_flag !== 1'b1 && n < 500) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        cmd(8'h00);
        cmd(8'h00);
        cursor_match = 1'b1;
        @(negedge core_clk);
        chk({status_bits, irq_mask, init_reg_pointer}, 15'h4000);
        chk({graphics_active, row_buffer_mode, cursor_out, blank_out}, 4'h5);
        reset_busy = 1'b1;
        @(negedge core_clk);
        chk({blank_out, hsync_en, vsync_en}, 3'h4);
        reset_busy = 1'b0;
        cursor_match = 1'b0;
        @(negedge core_clk);
        chk({blank_out, hsync_en, vsync_en}, 3'h7);
    endtask
    task automatic t_ptr();
        cmd(8'h1e);
        chk(init_reg_pointer, 4'he);
        cmd(8'hc5);
        cmd(8'ha0);
        chk({status_bits, irq_mask, init_reg_pointer}, 15'h400e);
    endtask
    task automatic t_irq();
        cmd(8'h7f);
        chk(irq_mask, 5'h1f);
        ev(5'h08);
        chk({interrupt_output, irq_bits}, 6'h28);
        cmd(8'h48);
        chk({irq_bits, status_bits}, 11'h020);
        cmd(8'h81);
        chk(irq_mask, 5'h1e);
        ev(5'h01);
        chk({irq_bits, status_bits}, 11'h021);
        cmd(8'h41);
        chk(status_bits, 6'h20);
    endtask
    task automatic t_disp();
        cursor_match = 1'b1;
        cmd(8'h31);
        chk(cursor_out, 1'b1);
        cmd(8'h30);
        chk(cursor_out, 1'b0);
        cmd(8'h29);
        chk(blank_out, 1'b1);
        pulse(line_start);
        chk(blank_out, 1'b0);
        cmd(8'h2c);
        chk({blank_out, display_address_bus_oe}, 2'b10);
        cmd(8'h29);
        chk(display_address_bus_oe, 1'b1);
        pulse(line_start);
    endtask
    task automatic t_gfx();
        cmd(8'h21);
        chk(graphics_active, 1'b0);
        pulse(row_boundary);
        chk(graphics_active, 1'b1);
        hblank_in = 1'b1;
        @(negedge core_clk);
        hblank_in = 1'b0;
        #1;
        chk(line_graphics_strobe, 1'b1);
    endtask
    // read waits for blanking
    task automatic t_ptr_read();
        ptr_addr = 14'h0123;
        cmd(8'ha4);
        chk({mem_req, delayed_ready_flag}, 2'b00);
        cmd(8'h1e);
        chk(delayed_ready_flag, 1'b0);
        hblank_in = 1'b1;
        mem(14'h0123, 1'b0);
        wait_rdy();
        chk(status_bits, 6'h22);
        hblank_in = 1'b0;
    endtask
    task automatic t_cursor();
        logic [7:0]  op[6] = '{8'hac, 8'haa, 8'had, 8'hab, 8'ha2, 8'ha9};
        logic [5:0]  we = 6'b011010;
        logic [5:0]  inc = 6'b101100;
        logic [13:0] c;
        c = 14'h0100;
        cmd(8'h28);
        cur_load_val = c;
        pulse(cur_load);
        for (int i = 0; i < 6; i++) begin
            cmd(op[i]);
            if (i < 5) begin
                mem(i == 4 ? ptr_addr : c, we[i]);
            end
            wait_rdy();
            c = c + 14'(inc[i]);
            chk(cursor_addr, c);
        end
    endtask
    // block write pauses outside blanking
    task automatic t_block();
        cur_load_val = 14'h0200;
        pulse(cur_load);
        ptr_addr = 14'h0202;
        cmd(8'h29);
        pulse(line_start);
        hblank_in = 1'b1;
        cmd(8'hbb);
        mem(14'h0200, 1'b1);
        hblank_in = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({mem_req, delayed_ready_flag}, 2'b00);
        hblank_in = 1'b1;
        mem(14'h0201, 1'b1);
        mem(14'h0202, 1'b1);
        wait_rdy();
        pulse(cur_load);
        cmd(8'hbd);
        for (int i = 0; i < 3; i++) begin
            mem(14'h0200 + 14'(i), 1'b0);
        end
        wait_rdy();
        chk(delayed_ready_flag, 1'b1);
        hblank_in = 1'b0;
    endtask
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        {hblank_in, vretrace_in, field_start, line_start, row_boundary} = 5'h0;
        {cursor_match, reset_busy, mem_ack, cur_load} = 4'h0;
        {stat_events, mac_addr, cur_load_val, ptr_addr} = 47'h0;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        t_reset();
        t_ptr();
        t_irq();
        t_disp();
        t_gfx();
        t_ptr_read();
        t_cursor();
        t_block();
        end_of_test();
    end
endmodule

// file: verilog/cmd_strobe_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser plus rising-edge pulse of the host write strobe
module cmd_strobe_sync (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic wr_n_pin,
    output logic      wr_done
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic s1_nxt;
    logic s2_nxt;
    logic s3_nxt;

    // s2 and s3 feed the edge detector; s1 is the metastability stage
    always_comb begin
        s1_nxt = wr_n_pin;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // trailing edge of active-low strobe: low then high
    assign wr_done = s2_r & ~s3_r;
endmodule

// file: verilog/video_display_command_unit.sv
`timescale 1ns/1ps
module video_display_command_unit #(
    parameter int ADDR_W = 14
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // host command port
    input  wire logic              cmd_wr_n,
    input  wire logic [7:0]        cmd_data,
    // raster timing from the timing chain (synchronous)
    input  wire logic              hblank_in,
    input  wire logic              vretrace_in,
    input  wire logic              field_start,
    input  wire logic              line_start,
    input  wire logic              row_boundary,
    input  wire logic              cursor_match,
    input  wire logic [ADDR_W-1:0] mac_addr,
    input  wire logic [vdcu_pkg::NSTAT-1:0] stat_events,
    input  wire logic              reset_busy,
    // memory access handshake
    output logic                   mem_req,
    output logic                   mem_we,
    output logic [ADDR_W-1:0]      mem_addr,
    input  wire logic              mem_ack,
    // loaded addresses
    input  wire logic              cur_load,
    input  wire logic [ADDR_W-1:0] cur_load_val,
    input  wire logic [ADDR_W-1:0] ptr_addr,
    // outputs
    output logic [ADDR_W-1:0]      cursor_addr,
    output logic [3:0]             init_reg_pointer,
    output logic                   init_two_top_bit_clr,
    output logic                   graphics_active,
    output logic                   mac_per_line,
    output logic                   line_graphics_strobe,
    output logic                   display_address_bus_oe,
    output logic                   blank_out,
    output logic                   hsync_en,
    output logic                   vsync_en,
    output logic                   cursor_out,
    output logic                   row_buffer_mode,
    output logic [4:0]             irq_bits,
    output logic [5:0]             status_bits,
    output logic [4:0]             irq_mask,
    output logic                   interrupt_output,
    output logic                   delayed_ready_flag
);
    logic wr_done;
    cmd_strobe_sync u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wr_n_pin (cmd_wr_n),
        .wr_done  (wr_done)
    );

    // data byte through two stages too
    logic [7:0] d1_r;
    logic [7:0] d2_r;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            d1_r <= 8'h00;
            d2_r <= 8'h00;
        end else begin
            d1_r <= cmd_data;
            d2_r <= d1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode
    function automatic logic is_delayed(input logic [7:0] c);
        is_delayed = (c == vdcu_pkg::CMD_RD_PTR) || (c == vdcu_pkg::CMD_WR_PTR)
                  || (c == vdcu_pkg::CMD_INC_CUR) || (c == vdcu_pkg::CMD_RD_CUR)
                  || (c == vdcu_pkg::CMD_WR_CUR) || (c == vdcu_pkg::CMD_RD_CUR_INC)
                  || (c == vdcu_pkg::CMD_WR_CUR_INC) || (c == vdcu_pkg::CMD_BLK_WR)
                  || (c == vdcu_pkg::CMD_BLK_RD);
    endfunction

    logic c_reset;
    logic c_ldptr;
    logic c_mode;
    logic c_clr;
    logic c_dis;
    logic c_en;
    logic c_dly;
    always_comb begin
        c_reset = wr_done && (d2_r == vdcu_pkg::CMD_MRESET);
        c_ldptr = wr_done && (d2_r[7:4] == vdcu_pkg::GRP_LOAD_PTR);
        c_mode  = wr_done && (d2_r[7:5] == vdcu_pkg::GRP_MODE);
        c_clr   = wr_done && (d2_r[7:5] == vdcu_pkg::GRP_CLR_STAT);
        c_dis   = wr_done && (d2_r[7:5] == vdcu_pkg::GRP_DIS_INT);
        c_en    = wr_done && (d2_r[7:5] == vdcu_pkg::GRP_EN_INT);
        // busy refuses delayed bytes
        c_dly   = wr_done && is_delayed(d2_r) && delayed_ready_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // instantaneous state
    logic       disp_on_r, disp_on_nxt;
    logic       float_r, float_nxt;
    logic       blank_r, blank_nxt;
    logic       pend_field_r, pend_field_nxt;
    logic       pend_line_r, pend_line_nxt;
    logic       gfx_req_r, gfx_req_nxt;
    logic       gfx_r, gfx_nxt;
    logic       curs_r, curs_nxt;
    logic       rowbuf_r, rowbuf_nxt;
    logic [3:0] ptr_r, ptr_nxt;
    logic       ir2clr_r, ir2clr_nxt;
    logic [4:0] mask_r, mask_nxt;
    logic [4:0] irq_r, irq_nxt;
    logic [4:0] stat_r, stat_nxt;
    logic       rdy_r, rdy_nxt;
    logic       hbl_q_r;
    logic       dly_done;

    always_comb begin
        disp_on_nxt    = disp_on_r;
        float_nxt      = float_r;
        blank_nxt      = blank_r;
        pend_field_nxt = pend_field_r;
        pend_line_nxt  = pend_line_r;
        gfx_req_nxt    = gfx_req_r;
        gfx_nxt        = gfx_r;
        curs_nxt       = curs_r;
        rowbuf_nxt     = rowbuf_r;
        ptr_nxt        = ptr_r;
        ir2clr_nxt     = 1'b0;
        mask_nxt       = mask_r;
        irq_nxt        = irq_r;
        stat_nxt       = stat_r;
        // graphics change lands only on a row boundary; reset clears it at once
        if (row_boundary) begin
            gfx_nxt = gfx_req_r;
        end
        // release blank at field or line start
        if ((pend_field_r && field_start) || (pend_line_r && line_start)) begin
            blank_nxt      = 1'b0;
            pend_field_nxt = 1'b0;
            pend_line_nxt  = 1'b0;
        end
        if (c_ldptr) begin
            ptr_nxt = d2_r[3:0];
        end
        if (c_mode) begin
            if (d2_r[vdcu_pkg::MB_CURS]) begin
                curs_nxt = d2_r[vdcu_pkg::MB_ONOFF];
            end
            if (d2_r[vdcu_pkg::MB_DISP]) begin
                if (d2_r[vdcu_pkg::MB_ONOFF]) begin
                    disp_on_nxt    = 1'b1;
                    float_nxt      = 1'b0;
                    pend_field_nxt = d2_r[vdcu_pkg::MB_OPT];
                    pend_line_nxt  = ~d2_r[vdcu_pkg::MB_OPT];
                end else begin
                    disp_on_nxt    = 1'b0;
                    blank_nxt      = 1'b1;
                    float_nxt      = d2_r[vdcu_pkg::MB_OPT];
                    pend_field_nxt = 1'b0;
                    pend_line_nxt  = 1'b0;
                end
            end
            if (!d2_r[vdcu_pkg::MB_CURS] && !d2_r[vdcu_pkg::MB_DISP]) begin
                gfx_req_nxt = d2_r[vdcu_pkg::MB_ONOFF];
            end
        end
        // events latch; set beats clear
        if (c_clr) begin
            stat_nxt = stat_nxt & ~d2_r[4:0];
            irq_nxt  = irq_nxt & ~d2_r[4:0];
        end
        if (c_dis) begin
            mask_nxt = mask_r & ~d2_r[4:0];
        end
        if (c_en) begin
            mask_nxt = mask_r | d2_r[4:0];
        end
        stat_nxt[vdcu_pkg::ST_READY] = stat_nxt[vdcu_pkg::ST_READY] | dly_done;
        stat_nxt = stat_nxt | stat_events;
        irq_nxt  = irq_nxt | ((stat_events
                 | ({4'h0, dly_done} << vdcu_pkg::ST_READY)) & mask_r);
        if (c_reset) begin
            mask_nxt       = 5'h00;
            irq_nxt        = 5'h00;
            stat_nxt       = 5'h00;
            blank_nxt      = 1'b1;
            disp_on_nxt    = 1'b0;
            float_nxt      = 1'b0;
            pend_field_nxt = 1'b0;
            pend_line_nxt  = 1'b0;
            curs_nxt       = 1'b0;
            gfx_req_nxt    = 1'b0;
            gfx_nxt        = 1'b0;
            rowbuf_nxt     = 1'b1;
            ptr_nxt        = vdcu_pkg::PTR_RESET;
            ir2clr_nxt     = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            disp_on_r    <= 1'b0;
            float_r      <= 1'b0;
            blank_r      <= 1'b1;
            pend_field_r <= 1'b0;
            pend_line_r  <= 1'b0;
            gfx_req_r    <= 1'b0;
            gfx_r        <= 1'b0;
            curs_r       <= 1'b0;
            rowbuf_r     <= 1'b1;
            ptr_r        <= vdcu_pkg::PTR_RESET;
            ir2clr_r     <= 1'b0;
            mask_r       <= 5'h00;
            irq_r        <= 5'h00;
            stat_r       <= 5'h00;
            hbl_q_r      <= 1'b0;
        end else begin
            disp_on_r    <= disp_on_nxt;
            float_r      <= float_nxt;
            blank_r      <= blank_nxt;
            pend_field_r <= pend_field_nxt;
            pend_line_r  <= pend_line_nxt;
            gfx_req_r    <= gfx_req_nxt;
            gfx_r        <= gfx_nxt;
            curs_r       <= curs_nxt;
            rowbuf_r     <= rowbuf_nxt;
            ptr_r        <= ptr_nxt;
            ir2clr_r     <= ir2clr_nxt;
            mask_r       <= mask_nxt;
            irq_r        <= irq_nxt;
            stat_r       <= stat_nxt;
            hbl_q_r      <= hblank_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delayed command sequencer
    vdcu_pkg::dly_state_t st_r, st_nxt;
    logic [7:0]        op_r, op_nxt;
    logic [ADDR_W-1:0] cur_r, cur_nxt;
    logic [ADDR_W-1:0] blk_r, blk_nxt;
    logic [1:0]        cnt_r, cnt_nxt;
    logic              can_run;

    // blanking or display off
    assign can_run = hblank_in || vretrace_in || !disp_on_r;

    always_comb begin
        st_nxt   = st_r;
        op_nxt   = op_r;
        cur_nxt  = cur_load ? cur_load_val : cur_r;
        blk_nxt  = blk_r;
        cnt_nxt  = cnt_r;
        rdy_nxt  = rdy_r;
        dly_done = 1'b0;
        case (st_r)
            vdcu_pkg::ST_IDLE: begin
                if (c_dly) begin
                    op_nxt  = d2_r;
                    rdy_nxt = 1'b0;
                    blk_nxt = cur_r;
                    if (d2_r == vdcu_pkg::CMD_INC_CUR) begin
                        st_nxt  = vdcu_pkg::ST_INC;
                        cnt_nxt = 2'(vdcu_pkg::INC_CYCLES - 1);
                    end else if (d2_r == vdcu_pkg::CMD_BLK_WR
                              || d2_r == vdcu_pkg::CMD_BLK_RD) begin
                        st_nxt = vdcu_pkg::ST_BLOCK;
                    end else begin
                        st_nxt = vdcu_pkg::ST_WAIT;
                    end
                end
            end
            vdcu_pkg::ST_WAIT: begin
                if (can_run) begin
                    st_nxt = vdcu_pkg::ST_ACC;
                end
            end
            vdcu_pkg::ST_ACC: begin
                if (mem_ack) begin
                    if (op_r == vdcu_pkg::CMD_RD_CUR_INC || op_r == vdcu_pkg::CMD_WR_CUR_INC) begin
                        cur_nxt = cur_r + 1'b1;
                    end
                    st_nxt   = vdcu_pkg::ST_IDLE;
                    rdy_nxt  = 1'b1;
                    dly_done = 1'b1;
                end
            end
            vdcu_pkg::ST_INC: begin
                if (cnt_r == 2'h0) begin
                    cur_nxt  = cur_r + 1'b1;
                    st_nxt   = vdcu_pkg::ST_IDLE;
                    rdy_nxt  = 1'b1;
                    dly_done = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            vdcu_pkg::ST_BLOCK: begin
                // one word per ack
                if (mem_ack) begin
                    if (blk_r == ptr_addr) begin
                        st_nxt   = vdcu_pkg::ST_IDLE;
                        rdy_nxt  = 1'b1;
                        dly_done = 1'b1;
                    end else begin
                        blk_nxt = blk_r + 1'b1;
                    end
                end
            end
            default: st_nxt = vdcu_pkg::ST_IDLE;
        endcase
        if (c_reset) begin
            st_nxt  = vdcu_pkg::ST_IDLE;
            rdy_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r  <= vdcu_pkg::ST_IDLE;
            op_r  <= 8'h00;
            cur_r <= '0;
            blk_r <= '0;
            cnt_r <= 2'h0;
            rdy_r <= 1'b1;
        end else begin
            st_r  <= st_nxt;
            op_r  <= op_nxt;
            cur_r <= cur_nxt;
            blk_r <= blk_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        mem_req = ((st_r == vdcu_pkg::ST_ACC) || (st_r == vdcu_pkg::ST_BLOCK)) && can_run;
        mem_we  = (op_r == vdcu_pkg::CMD_WR_PTR) || (op_r == vdcu_pkg::CMD_WR_CUR)
               || (op_r == vdcu_pkg::CMD_WR_CUR_INC) || (op_r == vdcu_pkg::CMD_BLK_WR);
        if (op_r == vdcu_pkg::CMD_RD_PTR || op_r == vdcu_pkg::CMD_WR_PTR) begin
            mem_addr = ptr_addr;
        end else if (st_r == vdcu_pkg::ST_BLOCK) begin
            mem_addr = blk_r;
        end else begin
            mem_addr = cur_r;
        end
    end

    assign cursor_addr            = cur_r;
    assign init_reg_pointer       = ptr_r;
    assign init_two_top_bit_clr   = ir2clr_r;
    assign graphics_active        = gfx_r;
    assign mac_per_line           = gfx_r;
    // strobe on the falling edge of blank each line
    assign line_graphics_strobe   = gfx_r && hbl_q_r && !hblank_in;
    assign display_address_bus_oe = !float_r;
    // syncs low during reset
    assign hsync_en               = !reset_busy;
    assign vsync_en               = !reset_busy;
    assign blank_out              = blank_r || reset_busy || hblank_in || vretrace_in;
    assign cursor_out             = curs_r && cursor_match;
    assign row_buffer_mode        = rowbuf_r;
    assign irq_bits               = irq_r;
    assign status_bits            = {rdy_r, stat_r};
    assign irq_mask               = mask_r;
    assign interrupt_output       = |irq_r;
    assign delayed_ready_flag     = rdy_r;
endmodule
